// *** bst_pkg.sv ***
`default_nettype none
package bst_pkg;
  localparam int IR_LEN       = 10;
  localparam int USER_LEN     = 32;
  localparam int ID_LEN       = 32;
  localparam int BSR_LEN_S    = 1029;
  localparam int BSR_LEN_M    = 1665;
  localparam int BSR_LEN_L    = 1941;
  localparam int PLL_LEN      = 16;
  localparam int IOSTD_W      = 4;
  localparam logic [9:0] OP_SAMPLE  = 10'h005;
  localparam logic [9:0] OP_EXTEST  = 10'h000;
  localparam logic [9:0] OP_BYPASS  = 10'h3FF;
  localparam logic [9:0] OP_USER    = 10'h007;
  localparam logic [9:0] OP_IDCODE  = 10'h006;
  localparam logic [9:0] OP_HIGHZ   = 10'h00B;
  localparam logic [9:0] OP_CLAMP   = 10'h00A;
  localparam logic [9:0] OP_CFGLD   = 10'h002;
  localparam logic [9:0] OP_RECFG   = 10'h001;
  localparam logic [9:0] OP_CFGIO   = 10'h00D;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [IR_LEN-1:0] IR_RESET = OP_IDCODE;
  localparam logic [3:0]  ID_VERSION = 4'h1;     // Arbitrary value
  localparam logic [15:0] ID_PART    = 16'hA5C3; // Arbitrary value
  localparam logic [10:0] ID_MAKER   = 11'h2B5;  // Arbitrary value
  localparam logic [31:0] USERCODE_RST = 32'hFFFFFFFF;

  typedef enum logic [3:0] {
    ST_RESET = 4'hF, ST_IDLE = 4'hC, ST_SEL_DR = 4'h7, ST_CAP_DR = 4'h6,
    ST_SH_DR = 4'h2, ST_EX1_DR = 4'h1, ST_PA_DR = 4'h3, ST_EX2_DR = 4'h0,
    ST_UP_DR = 4'h5, ST_SEL_IR = 4'h4, ST_CAP_IR = 4'hE, ST_SH_IR = 4'hA,
    ST_EX1_IR = 4'h9, ST_PA_IR = 4'hB, ST_EX2_IR = 4'h8, ST_UP_IR = 4'hD
  } bst_state_t;
endpackage
`default_nettype wire

// *** bst_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** bst_tap.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_tap
  import bst_pkg::*;
#(
  parameter int NPIN    = 8,
  parameter int BSR_LEN = BSR_LEN_S
) (
  input  wire logic            core_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            tck_i,
  input  wire logic            tms_i,
  input  wire logic            tdi_i,
  input  wire logic            trst_n_i,
  output logic                 tdo_o,
  output logic                 tdo_oe_o,
  input  wire logic [NPIN-1:0] pin_in_i,
  input  wire logic [NPIN-1:0] core_out_i,
  input  wire logic [NPIN-1:0] core_oe_i,
  input  wire logic [NPIN-1:0] keeper_en_i,
  input  wire logic            config_busy_i,
  input  wire logic            config_done_i,
  input  wire logic [31:0]     usercode_i,
  output logic [NPIN-1:0]      pin_out_o,
  output logic [NPIN-1:0]      pin_oe_o,
  output logic [NPIN-1:0]      pin_keep_o,
  output logic [NPIN*IOSTD_W-1:0] io_std_o,
  output logic [PLL_LEN-1:0]   pll_cfg_o,
  output logic                 cfg_data_o,
  output logic                 cfg_data_vld_o,
  output logic                 reconfig_pulse_o,
  output logic                 cfg_abort_o,
  output logic                 test_conflict_o
);
  localparam int IOS_LEN = NPIN * IOSTD_W;

  logic                 tck_s;
  logic                 tms_s;
  logic                 tdi_s;
  logic                 trst_n_s;
  logic [NPIN-1:0]      pin_s;
  logic                 busy_s;
  logic                 done_s;
  logic                 tck_d_reg;
  logic                 rise;
  logic                 fall;
  bst_state_t           st_reg;
  bst_state_t           st_next;
  logic [IR_LEN-1:0]    ir_sh_reg;
  logic [IR_LEN-1:0]    ir_reg;
  logic                 byp_reg;
  logic [ID_LEN-1:0]    id_sh_reg;
  logic [BSR_LEN-1:0]   bsr_sh_reg;
  logic [BSR_LEN-1:0]   bsr_up_reg;
  logic [IOS_LEN-1:0]   ios_sh_reg;
  logic [PLL_LEN-1:0]   pll_sh_reg;
  logic                 tdo_next;
  logic                 is_sample;
  logic                 is_extest;
  logic                 is_user;
  logic                 is_id;
  logic                 is_highz;
  logic                 is_clamp;
  logic                 is_cfgld;
  logic                 is_cfgio;
  logic                 is_recfg;
  logic                 use_bsr;
  logic                 use_pll;
  logic                 bsr_drive;
  logic [NPIN-1:0]      drv_out;
  logic [NPIN-1:0]      drv_oe;
  logic                 ld_recfg;
  logic                 ld_cfgio;

  // Pin-side inputs all cross into core_clk through two flops
  bst_sync #(.W(NPIN + 6)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .d_i        ({tck_i, tms_i, tdi_i, trst_n_i, config_busy_i, config_done_i, pin_in_i}),
    .q_o        ({tck_s, tms_s, tdi_s, trst_n_s, busy_s, done_s, pin_s})
  );

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tck_d_reg <= 1'b0;
    end else begin
      tck_d_reg <= tck_s;
    end
  end

  assign rise = tck_s & ~tck_d_reg;
  assign fall = ~tck_s & tck_d_reg;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_RESET:  st_next = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   st_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  st_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_next = tms_s ? ST_UP_DR  : ST_PA_DR;
      ST_PA_DR:  st_next = tms_s ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: st_next = tms_s ? ST_UP_DR  : ST_SH_DR;
      ST_UP_DR:  st_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_next = tms_s ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: st_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  st_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_next = tms_s ? ST_UP_IR  : ST_PA_IR;
      ST_PA_IR:  st_next = tms_s ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: st_next = tms_s ? ST_UP_IR  : ST_SH_IR;
      ST_UP_IR:  st_next = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   st_next = ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_RESET;
    end else if (!trst_n_s) begin
      st_reg <= ST_RESET;
    end else if (rise) begin
      st_reg <= st_next;
    end
  end

  // Instruction register, ten bits, reset selects IDCODE
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ir_sh_reg <= '0;
      ir_reg    <= IR_RESET;
    end else if (st_reg == ST_RESET) begin
      ir_reg    <= IR_RESET;
    end else if (rise) begin
      case (st_reg)
        ST_CAP_IR: ir_sh_reg <= {{(IR_LEN-2){1'b0}}, IR_CAPTURE};
        ST_SH_IR:  ir_sh_reg <= {tdi_s, ir_sh_reg[IR_LEN-1:1]};
        ST_UP_IR:  ir_reg    <= ir_sh_reg;
        default:   ir_sh_reg <= ir_sh_reg;
      endcase
    end
  end

  assign is_sample = (ir_reg == OP_SAMPLE);
  assign is_extest = (ir_reg == OP_EXTEST);
  assign is_user   = (ir_reg == OP_USER);
  assign is_id     = (ir_reg == OP_IDCODE);
  assign is_highz  = (ir_reg == OP_HIGHZ);
  assign is_clamp  = (ir_reg == OP_CLAMP);
  assign is_cfgld  = (ir_reg == OP_CFGLD);
  assign is_cfgio  = (ir_reg == OP_CFGIO);
  assign is_recfg  = (ir_reg == OP_RECFG);
  assign use_bsr   = is_sample | is_extest;
  assign use_pll   = is_cfgio & ~done_s;

  // One-bit bypass stage; also the path for unknown opcodes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      byp_reg <= 1'b0;
    end else if (rise) begin
      if (st_reg == ST_CAP_DR) begin
        byp_reg <= 1'b0;
      end else if (st_reg == ST_SH_DR) begin
        byp_reg <= tdi_s;
      end
    end
  end

  // Shared 32-bit shifter for IDCODE and USERCODE
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      id_sh_reg <= '0;
    end else if (rise) begin
      if (st_reg == ST_CAP_DR) begin
        if (is_user) begin
          id_sh_reg <= usercode_i;
        end else begin
          id_sh_reg <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
        end
      end else if (st_reg == ST_SH_DR) begin
        id_sh_reg <= {tdi_s, id_sh_reg[ID_LEN-1:1]};
      end
    end
  end

  // Boundary register: first NPIN cells are inputs, next NPIN are outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bsr_sh_reg <= '0;
      bsr_up_reg <= '0;
    end else if (rise && use_bsr) begin
      if (st_reg == ST_CAP_DR) begin
        bsr_sh_reg[NPIN-1:0] <= pin_s;
        if (is_sample) begin
          bsr_sh_reg[2*NPIN-1:NPIN] <= core_out_i;
        end
      end else if (st_reg == ST_SH_DR) begin
        bsr_sh_reg <= {tdi_s, bsr_sh_reg[BSR_LEN-1:1]};
      end else if (st_reg == ST_UP_DR) begin
        bsr_up_reg <= bsr_sh_reg;
      end
    end
  end

  // I/O standard chain, PLL bits appended before configuration completes
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ios_sh_reg <= '0;
      pll_sh_reg <= '0;
      io_std_o   <= '0;
      pll_cfg_o  <= '0;
    end else if (rise && is_cfgio) begin
      if (st_reg == ST_SH_DR) begin
        if (use_pll) begin
          pll_sh_reg <= {tdi_s, pll_sh_reg[PLL_LEN-1:1]};
          ios_sh_reg <= {pll_sh_reg[0], ios_sh_reg[IOS_LEN-1:1]};
        end else begin
          ios_sh_reg <= {tdi_s, ios_sh_reg[IOS_LEN-1:1]};
        end
      end else if (st_reg == ST_UP_DR) begin
        io_std_o <= ios_sh_reg;
        if (use_pll) begin
          pll_cfg_o <= pll_sh_reg;
        end
      end
    end
  end

  always_comb begin
    if (is_id || is_user) begin
      tdo_next = id_sh_reg[0];
    end else if (use_bsr) begin
      tdo_next = bsr_sh_reg[0];
    end else if (is_cfgio) begin
      tdo_next = ios_sh_reg[0];
    end else begin
      tdo_next = byp_reg;
    end
  end

  // TDO changes on falling TCK as the port protocol expects
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (fall) begin
      if (st_reg == ST_SH_IR) begin
        tdo_o    <= ir_sh_reg[0];
        tdo_oe_o <= 1'b1;
      end else if (st_reg == ST_SH_DR) begin
        tdo_o    <= tdo_next;
        tdo_oe_o <= 1'b1;
      end else begin
        tdo_oe_o <= 1'b0;
      end
    end
  end

  assign bsr_drive = is_extest | is_clamp;
  // New opcode still sits in the shifter during Update-IR
  assign ld_recfg  = (ir_sh_reg == OP_RECFG);
  assign ld_cfgio  = (ir_sh_reg == OP_CFGIO);

  // Next drive, so the keeper mask follows this cycle's enables
  always_comb begin
    drv_out = core_out_i;
    drv_oe  = core_oe_i;
    for (int i = 0; i < NPIN; i++) begin
      if (bsr_drive) begin
        drv_out[i] = bsr_up_reg[NPIN+i];
        drv_oe[i]  = bsr_up_reg[2*NPIN+i];
      end else if (is_highz) begin
        drv_out[i] = 1'b0;
        drv_oe[i]  = 1'b0;
      end
    end
  end

  // Keepers win over any forced high impedance
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_out_o  <= '0;
      pin_oe_o   <= '0;
      pin_keep_o <= '0;
    end else begin
      pin_out_o  <= drv_out;
      pin_oe_o   <= drv_oe;
      if (is_highz || bsr_drive) begin
        pin_keep_o <= keeper_en_i & ~drv_oe;
      end else begin
        pin_keep_o <= keeper_en_i;
      end
    end
  end

  // Data and strobe leave on the same edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_data_o     <= 1'b0;
      cfg_data_vld_o <= 1'b0;
    end else begin
      cfg_data_vld_o <= rise && is_cfgld && (st_reg == ST_SH_DR);
      cfg_data_o     <= tdi_s;
    end
  end

  // Request only; the real pin is never driven
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reconfig_pulse_o <= 1'b0;
    end else begin
      reconfig_pulse_o <= rise && ((st_reg == ST_UP_IR && ld_recfg) || (st_reg == ST_UP_DR && is_recfg));
    end
  end

  // Loading CONFIG_IO mid-configuration stops the engine
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_abort_o <= 1'b0;
    end else begin
      cfg_abort_o <= rise && ld_cfgio && busy_s && (st_reg == ST_UP_IR);
    end
  end

  // Flag only; the scan itself still runs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      test_conflict_o <= 1'b0;
    end else begin
      test_conflict_o <= busy_s && (use_bsr || is_clamp || is_highz);
    end
  end
endmodule
`default_nettype wire

// *** bst_tap_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_tap_chk
  import bst_pkg::*;
#(
  parameter int NPIN = 8
) (
  input wire logic                    core_clk_i,
  input wire logic                    rst_n_i,
  input wire logic                    tck_i,
  input wire logic                    tdo_o,
  input wire logic                    tdo_oe_o,
  input wire logic [NPIN-1:0]         keeper_en_i,
  input wire logic [NPIN-1:0]         pin_keep_o,
  input wire logic [NPIN-1:0]         pin_oe_o,
  input wire logic [NPIN*IOSTD_W-1:0] io_std_o,
  input wire logic [PLL_LEN-1:0]      pll_cfg_o,
  input wire logic                    config_busy_i,
  input wire logic                    config_done_i,
  input wire logic                    cfg_data_vld_o,
  input wire logic                    reconfig_pulse_o,
  input wire logic                    cfg_abort_o,
  input wire logic                    test_conflict_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_reset_quiet: assert property ($rose(rst_n_i) |-> !tdo_oe_o && pll_cfg_o == '0 && io_std_o == '0)
    else $error("outputs not clear after reset");
  chk_tdo_on_fall: assert property ($changed(tdo_o) |-> !$past(tck_i, 3))
    else $error("tdo moved while tck high");
  chk_keep_enabled: assert property ($stable(keeper_en_i) |-> (pin_keep_o & ~keeper_en_i) == '0)
    else $error("keeper active on disabled pin");
  chk_abort_strobe: assert property (cfg_abort_o |=> !cfg_abort_o)
    else $error("abort longer than one cycle");
  chk_abort_busy: assert property (cfg_abort_o |-> $past(config_busy_i, 3))
    else $error("abort without configuration");
  chk_reconfig_strobe: assert property (reconfig_pulse_o |=> !reconfig_pulse_o)
    else $error("reconfig pulse too long");
  chk_shift_strobe: assert property (cfg_data_vld_o |=> !cfg_data_vld_o [*8])
    else $error("load strobes too close");
  chk_shift_in_scan: assert property (cfg_data_vld_o |-> tdo_oe_o)
    else $error("load strobe outside shift");
  chk_pll_locked: assert property (config_done_i && $past(config_done_i, 3) && $past(config_done_i, 6)
    |-> $stable(pll_cfg_o))
    else $error("pll bits changed after config");

  cover property (cfg_abort_o);
  cover property (reconfig_pulse_o);
  cover property (cfg_data_vld_o);
  cover property ($rose(test_conflict_o));
endmodule
bind bst_tap bst_tap_chk #(.NPIN(NPIN)) u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .keeper_en_i(keeper_en_i), .pin_keep_o(pin_keep_o), .pin_oe_o(pin_oe_o), .io_std_o(io_std_o),
  .pll_cfg_o(pll_cfg_o), .config_busy_i(config_busy_i), .config_done_i(config_done_i),
  .cfg_data_vld_o(cfg_data_vld_o), .reconfig_pulse_o(reconfig_pulse_o), .cfg_abort_o(cfg_abort_o),
  .test_conflict_o(test_conflict_o)
);
`default_nettype wire

// *** bst_jtag_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_jtag_host (
  input  wire logic core_clk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // 64 ns tck, idles low between frames; tdo taken just before the rise
  task automatic step(input logic ms, input logic di, output logic dout);
    tms_o = ms;
    tdi_o = di;
    repeat (8) @(negedge core_clk_i);
    dout = tdo_i;
    tck_o = 1'b1;
    repeat (8) @(negedge core_clk_i);
    tck_o = 1'b0;
  endtask
  task automatic go_idle();
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
  task automatic scan(input logic ir, input int len, input logic [63:0] din, output logic [63:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b0, d);
    if (ir) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    // Cells past bit 63 are filled with zero and their output dropped
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, (i < 64) ? din[i] : 1'b0, d);
      if (i < 64) begin
        dout[i] = d;
      end
    end
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
endmodule
`default_nettype wire

// *** bst_tap_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module bst_tap_bench;
  import bst_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, trst_n = 1'b1, busy = 1'b0, done = 1'b0;
  logic        tck, tms, tdi, tdo, tdo_oe, c_dat, c_vld, rcf, abt, conf;
  logic [7:0]  pin_in = 8'h00, c_out = 8'h00, c_oe = 8'h00, keep_en = 8'h0F, p_out, p_oe, p_keep;
  logic [31:0] ucode = 32'h5A3C96E1, io_std;
  logic [15:0] pll;
  logic [63:0] q, cbits;
  int          n_errors = 0, num_checks = 0, n_vld = 0, n_rcf = 0, n_abt = 0;

  bst_tap #(.NPIN(8), .BSR_LEN(BSR_LEN_S)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in), .core_out_i(c_out), .core_oe_i(c_oe),
    .keeper_en_i(keep_en), .config_busy_i(busy), .config_done_i(done), .usercode_i(ucode),
    .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_keep_o(p_keep), .io_std_o(io_std), .pll_cfg_o(pll),
    .cfg_data_o(c_dat), .cfg_data_vld_o(c_vld), .reconfig_pulse_o(rcf), .cfg_abort_o(abt),
    .test_conflict_o(conf));
  bst_jtag_host host (.core_clk_i(clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (c_vld) begin
      cbits <= {c_dat, cbits[63:1]};
      n_vld <= n_vld + 1;
    end
    n_rcf <= n_rcf + int'(rcf);
    n_abt <= n_abt + int'(abt);
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic ir(input logic [9:0] op);
    host.scan(1'b1, IR_LEN, {54'h0, op}, q);
    check("ir_capture", 64'(q[1:0]), 64'(IR_CAPTURE));
  endtask
  task automatic dr(input int len, input logic [63:0] din);
    host.scan(1'b0, len, din, q);
  endtask

  task automatic t_ident();
    dr(32, 64'h0);
    check("idcode", q, 64'({ID_VERSION, ID_PART, ID_MAKER, 1'b1}));
    ir(OP_USER);
    dr(32, 64'h0);
    check("usercode", q, 64'(ucode));
    trst_n = 1'b0;
    repeat (4) @(negedge clk);
    trst_n = 1'b1;
    repeat (4) @(negedge clk);
    host.go_idle();
    dr(32, 64'h0);
    check("id_after_trst", q, 64'({ID_VERSION, ID_PART, ID_MAKER, 1'b1}));
    $display("test ident done");
  endtask
  task automatic t_bypass();
    logic [9:0] ops [3] = '{OP_BYPASS, 10'h155, 10'h3F0};
    foreach (ops[i]) begin
      ir(ops[i]);
      dr(8, 64'hB6);
      check("bypass", q, 64'h6C);
    end
    $display("test bypass done");
  endtask
  task automatic t_pins();
    pin_in = 8'hA5;
    c_out = 8'h99;
    c_oe = 8'h0F;
    keep_en = 8'h3C;
    ir(OP_SAMPLE);
    dr(BSR_LEN_S, 64'hF03C00);
    check("sample_cap", 64'(q[7:0]), 64'hA5);
    check("sample_out", 64'(q[15:8]), 64'h99);
    check("sample_pass", 64'({p_out, p_oe}), 64'h990F);
    ir(OP_EXTEST);
    check("extest_drive", 64'({p_out, p_oe}), 64'h3CF0);
    pin_in = 8'h5A;
    dr(BSR_LEN_S, 64'hF03C00);
    check("extest_cap", 64'(q[7:0]), 64'h5A);
    ir(OP_HIGHZ);
    check("highz", 64'({p_oe, p_keep}), 64'h003C);
    dr(8, 64'hB6);
    check("highz_bypass", q, 64'h6C);
    ir(OP_CLAMP);
    check("clamp", 64'({p_out, p_oe, p_keep}), 64'h3CF00C);
    $display("test pins done");
  endtask
  task automatic t_config();
    int base_abt;
    int base_rcf;
    int base_vld;
    ir(OP_CFGIO);
    dr(48, 64'hC3A512345678);
    check("io_std", 64'(io_std), 64'h12345678);
    check("pll_pre", 64'(pll), 64'hC3A5);
    done = 1'b1;
    dr(32, 64'h9ABCDEF0);
    check("io_std_user", 64'(io_std), 64'h9ABCDEF0);
    check("pll_post", 64'(pll), 64'hC3A5);
    done = 1'b0;
    busy = 1'b1;
    ir(OP_EXTEST);
    check("conflict", 64'(conf), 64'h1);
    busy = 1'b0;
    repeat (4) @(negedge clk);
    check("conflict_clear", 64'(conf), 64'h0);
    busy = 1'b1;
    base_abt = n_abt;
    ir(OP_CFGIO);
    check("abort", 64'(n_abt - base_abt), 64'h1);
    busy = 1'b0;
    base_rcf = n_rcf;
    ir(OP_RECFG);
    check("reconfig", 64'(n_rcf - base_rcf), 64'h1);
    dr(8, 64'h00);
    check("reconfig_dr", 64'(n_rcf - base_rcf), 64'h2);
    base_vld = n_vld;
    ir(OP_CFGLD);
    dr(8, 64'h4D);
    check("cfg_bits", 64'(cbits[63:56]), 64'h4D);
    check("cfg_count", 64'(n_vld - base_vld), 64'h8);
    $display("test config done");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    host.go_idle();
    t_ident();
    t_bypass();
    t_pins();
    t_config();
    results();
  end
  // Two full boundary scans set the pace, about 41k cycles; give up near twice that
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
